// file: src/bya_pkg.sv
package bya_pkg;
	// opcode group and the bit that picks the carry variant
	localparam logic [2:0] OP_GROUP = 3'h1;
	localparam int OP_GROUP_LSB = 5;
	localparam int CARRY_SEL_BIT = 4;
	localparam int REG_FORM_BIT = 3;
	// low nibble patterns with the carry-select bit ignored
	localparam logic [3:0] LOW_IMM = 4'h4;
	localparam logic [3:0] LOW_DIR = 4'h5;
	localparam logic [2:0] LOW_IND = 3'h3;
	// full opcodes of the plain immediate and direct sum forms
	localparam logic [7:0] OP_ADD_IMM = 8'h24;
	localparam logic [7:0] OP_ADD_DIR = 8'h25;
	// bank register addressing: bank select above a three-bit index
	localparam int BANK_W = 2;
	localparam int REG_IDX_W = 3;
	// reset values
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic FLAG_RESET = 1'b0;
	// carry positions inside the ripple chain
	localparam int NIBBLE_CARRY_POS = 4;
	localparam int BIT6_CARRY_POS = 7;
	localparam int BIT7_CARRY_POS = 8;

	typedef enum logic [2:0] {
		SRC_NONE,
		SRC_REG,
		SRC_DIR,
		SRC_IND,
		SRC_IMM
	} bya_src_e;
endpackage : bya_pkg

// file: src/bya_sum_if.sv
`timescale 1ns/100ps
interface bya_sum_if;
	logic [7:0] augend;
	logic [7:0] addend;
	logic carryIn;
	logic [7:0] sum;
	logic carryOut;
	logic nibbleCarry;
	logic signedWrap;

	modport core (
		input augend,
		input addend,
		input carryIn,
		output sum,
		output carryOut,
		output nibbleCarry,
		output signedWrap
	);
	modport user (
		output augend,
		output addend,
		output carryIn,
		input sum,
		input carryOut,
		input nibbleCarry,
		input signedWrap
	);
endinterface : bya_sum_if

// file: src/bya_sum_core.sv
`timescale 1ns/100ps
module bya_sum_core (
	bya_sum_if.core sumPort
);
	import bya_pkg::*;

	logic [8:0] chain;

	// ripple chain so the inner bit carries stay visible for the flags
	assign chain[0] = sumPort.carryIn;
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			assign sumPort.sum[i] = sumPort.augend[i] ^ sumPort.addend[i] ^ chain[i];
			assign chain[i + 1] = (sumPort.augend[i] & sumPort.addend[i])
				| (chain[i] & (sumPort.augend[i] ^ sumPort.addend[i]));
		end
	endgenerate

	// carry from bit 7 and bit 3
	assign sumPort.carryOut = chain[BIT7_CARRY_POS];
	assign sumPort.nibbleCarry = chain[NIBBLE_CARRY_POS];
	// wrap when bit 6 and bit 7 carries differ
	assign sumPort.signedWrap = chain[BIT6_CARRY_POS] ^ chain[BIT7_CARRY_POS];
endmodule : bya_sum_core

// file: src/bya_byte_adder.sv
//
// Behaviour
// - plain sum writes accumulator
// - carry and nibble carry from bits 7, 3
// - wrap flag on differing bit 6/7 carries
// - register, direct, indirect and immediate sources
// - direct form 0x25, two bytes, one cycle
// - immediate form 0x24 uses second byte
// - carry variant also adds carry flag
// - carry variant updates wrap flag likewise
`timescale 1ns/100ps
module bya_byte_adder (
	input wire logic clk,
	input wire logic rst,
	input wire logic instrValid,
	input wire logic [7:0] opcode,
	input wire logic [7:0] instrArg,
	input wire logic [bya_pkg::BANK_W-1:0] bankSel,
	output logic [7:0] fetchAddr,
	input wire logic [7:0] fetchData,
	output logic [7:0] derefAddr,
	input wire logic [7:0] derefData,
	input wire logic accLoad,
	input wire logic [7:0] accLoadData,
	input wire logic carryLoad,
	input wire logic carryLoadValue,
	output logic [7:0] accOut,
	output logic carryOut,
	output logic nibbleCarryOut,
	output logic signedWrapOut,
	output logic sumDone
);
	import bya_pkg::*;

	bya_src_e form;
	logic go;
	logic withCarry;
	logic [7:0] srcByte;
	logic [7:0] acc_q;
	logic carry_q;
	logic nibble_q;
	logic wrap_q;
	logic done_q;

	bya_sum_if sumBus ();

	function automatic bya_src_e decodeForm(input logic [7:0] op);
		bya_src_e f;
		f = SRC_NONE;
		if (op[7:OP_GROUP_LSB] == OP_GROUP) begin
			if (op[REG_FORM_BIT])
				f = SRC_REG;
			else if (op[3:0] == LOW_DIR)
				f = SRC_DIR;
			else if (op[3:0] == LOW_IMM)
				f = SRC_IMM;
			else if (op[3:1] == LOW_IND)
				f = SRC_IND;
		end
		return f;
	endfunction : decodeForm

	assign form = decodeForm(opcode);
	assign go = instrValid && (form != SRC_NONE);
	// carry variant chosen by one opcode bit
	assign withCarry = opcode[CARRY_SEL_BIT];

	// addresses are combinational so every form finishes in one cycle
	always_comb begin
		fetchAddr = 8'h00;
		unique case (form)
			SRC_REG: fetchAddr = {3'h0, bankSel, opcode[REG_IDX_W-1:0]};
			// direct address is the second byte
			SRC_DIR: fetchAddr = instrArg;
			SRC_IND: fetchAddr = {3'h0, bankSel, 2'h0, opcode[0]};
			SRC_IMM, SRC_NONE: fetchAddr = 8'h00;
		endcase
	end

	// pointer register content addresses the operand
	assign derefAddr = fetchData;

	always_comb begin
		srcByte = 8'h00;
		unique case (form)
			SRC_REG, SRC_DIR: srcByte = fetchData;
			SRC_IND: srcByte = derefData;
			SRC_IMM: srcByte = instrArg;
			SRC_NONE: srcByte = 8'h00;
		endcase
	end

	assign sumBus.augend = acc_q;
	assign sumBus.addend = srcByte;
	assign sumBus.carryIn = withCarry & carry_q;

	bya_sum_core u_core (
		.sumPort(sumBus.core)
	);

	// a sum in the same cycle as a load wins; the load is lost
	// accumulator write-back
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			acc_q <= ACC_RESET;
		else if (go)
			acc_q <= sumBus.sum;
		else if (accLoad)
			acc_q <= accLoadData;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			carry_q <= FLAG_RESET;
			nibble_q <= FLAG_RESET;
		end else if (go) begin
			carry_q <= sumBus.carryOut;
			nibble_q <= sumBus.nibbleCarry;
		end else if (carryLoad) begin
			carry_q <= carryLoadValue;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			wrap_q <= FLAG_RESET;
		else if (go)
			wrap_q <= sumBus.signedWrap;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			done_q <= 1'b0;
		else
			done_q <= go;
	end

	assign accOut = acc_q;
	assign carryOut = carry_q;
	assign nibbleCarryOut = nibble_q;
	assign signedWrapOut = wrap_q;
	assign sumDone = done_q;

	// reference arithmetic for the checks below
	logic refCin;
	logic [8:0] refSum;
	logic [4:0] refNib;
	logic [7:0] refLow;
	assign refCin = withCarry & carry_q;
	assign refSum = {1'b0, acc_q} + {1'b0, srcByte} + {8'h00, refCin};
	assign refNib = {1'b0, acc_q[3:0]} + {1'b0, srcByte[3:0]} + {4'h0, refCin};
	assign refLow = {1'b0, acc_q[6:0]} + {1'b0, srcByte[6:0]} + {7'h00, refCin};

	accum_result_a: assert property (@(posedge clk) disable iff (rst)
		go |=> accOut == $past(refSum[7:0]))
		else $error("accumulator does not hold the sum");
	carry_flag_a: assert property (@(posedge clk) disable iff (rst)
		go |=> carryOut == $past(refSum[8]) && nibbleCarryOut == $past(refNib[4]))
		else $error("carry or nibble carry wrong");
	wrap_flag_a: assert property (@(posedge clk) disable iff (rst)
		go |=> signedWrapOut == ($past(refLow[7]) ^ $past(refSum[8])))
		else $error("signed wrap flag wrong");
	reg_addr_a: assert property (@(posedge clk) disable iff (rst)
		(instrValid && opcode[7:3] == 5'h05) |-> fetchAddr == {3'h0, bankSel, opcode[2:0]})
		else $error("bank register address wrong");
	direct_form_a: assert property (@(posedge clk) disable iff (rst)
		(instrValid && opcode == OP_ADD_DIR) |-> fetchAddr == instrArg ##1 sumDone)
		else $error("direct form not fetched or not done in one cycle");
	imm_form_a: assert property (@(posedge clk) disable iff (rst)
		(instrValid && opcode == OP_ADD_IMM && !accLoad) |=>
		accOut == 8'($past(acc_q) + $past(instrArg)))
		else $error("immediate sum wrong");
	carry_add_a: assert property (@(posedge clk) disable iff (rst)
		(go && withCarry && carry_q) |=> accOut == 8'($past(acc_q) + $past(srcByte) + 8'h01))
		else $error("carry variant ignored the carry");
	wrap_carry_a: assert property (@(posedge clk) disable iff (rst)
		(go && withCarry && refLow[7] == refSum[8]) |=> !signedWrapOut)
		else $error("wrap flag not cleared on agreeing carries");
	ind_addr_a: assert property (@(posedge clk) disable iff (rst)
		(instrValid && opcode[7:1] == 7'h13) |->
		fetchAddr == {3'h0, bankSel, 2'h0, opcode[0]} && derefAddr == fetchData)
		else $error("indirect pointer addressing wrong");
	idle_hold_a: assert property (@(posedge clk) disable iff (rst)
		(!go && !accLoad) |=> $stable(accOut) && !sumDone)
		else $error("accumulator moved without a sum");
	// nibble and wrap flags have no load path, so only a sum may move them
	wrap_hold_a: assert property (@(posedge clk) disable iff (rst)
		!go |=> $stable(signedWrapOut) && $stable(nibbleCarryOut))
		else $error("wrap or nibble flag moved without a sum");
	wrap_carry_set_a: assert property (@(posedge clk) disable iff (rst)
		(go && withCarry && refLow[7] != refSum[8]) |=> signedWrapOut)
		else $error("wrap flag not set on differing carries");
	imm_operand_a: assert property (@(posedge clk) disable iff (rst)
		(instrValid && form == SRC_IMM) |-> srcByte == instrArg)
		else $error("immediate byte not used as operand");
	single_cycle_a: assert property (@(posedge clk) disable iff (rst)
		(instrValid && (form == SRC_REG || form == SRC_IND)) |=> sumDone)
		else $error("register or indirect form not done in one cycle");
	refused_op_a: assert property (@(posedge clk) disable iff (rst)
		(instrValid && form == SRC_NONE) |=> !sumDone && $stable(signedWrapOut))
		else $error("foreign opcode acted");

	cover_direct_c: cover property (@(posedge clk) disable iff (rst)
		instrValid && opcode == OP_ADD_DIR);
	cover_indirect_c: cover property (@(posedge clk) disable iff (rst)
		go && form == SRC_IND);
	cover_wrap_c: cover property (@(posedge clk) disable iff (rst)
		go && withCarry && carry_q ##1 signedWrapOut);
	cover_backtoback_c: cover property (@(posedge clk) disable iff (rst)
		go ##1 go);
	cover_load_clash_c: cover property (@(posedge clk) disable iff (rst)
		go && accLoad && carryLoad);
endmodule : bya_byte_adder

// file: tb/bya_mem_model.sv
`timescale 1ns/100ps
module bya_mem_model (
	input wire logic [7:0] fetchAddr,
	output logic [7:0] fetchData,
	input wire logic [7:0] derefAddr,
	output logic [7:0] derefData
);
	logic [7:0] mem [256];
	// filled with a pattern so an unset cell reads as zero only at address 0x5a
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5a;
		end
	end
	// async read: data answers in the same cycle as the address
	assign fetchData = mem[fetchAddr];
	assign derefData = mem[derefAddr];
endmodule : bya_mem_model

// file: tb/bya_byte_adder_tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e, m) begin checksDone++; if ((g) !== (e)) begin badCount++; \
	$display("unexpected at %0t: %s", $time, m); end end
module bya_byte_adder_tb_top;
	logic clk, rst, instrValid, accLoad, carryLoad, carryLoadValue;
	logic [7:0] opcode, instrArg, accLoadData, fetchAddr, fetchData, derefAddr, derefData;
	logic [7:0] accOut, accExp;
	logic [1:0] bankSel;
	logic carryOut, nibbleCarryOut, signedWrapOut, sumDone, cExp;
	int badCount, checksDone;
	logic [7:0] ops [12] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h2f,
		8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h3f};
	logic [7:0] vals [12] = '{8'h01, 8'h80, 8'h0f, 8'h7f, 8'haa, 8'h01,
		8'h01, 8'h80, 8'h0f, 8'h7f, 8'haa, 8'hff};
	logic [7:0] accs [12] = '{8'h7f, 8'h80, 8'h01, 8'h01, 8'hc3, 8'hff,
		8'h7f, 8'h80, 8'h01, 8'h00, 8'hc3, 8'h00};
	bya_byte_adder dut_u (.clk(clk), .rst(rst), .instrValid(instrValid), .opcode(opcode),
		.instrArg(instrArg), .bankSel(bankSel), .fetchAddr(fetchAddr), .fetchData(fetchData),
		.derefAddr(derefAddr), .derefData(derefData), .accLoad(accLoad),
		.accLoadData(accLoadData), .carryLoad(carryLoad), .carryLoadValue(carryLoadValue),
		.accOut(accOut), .carryOut(carryOut), .nibbleCarryOut(nibbleCarryOut),
		.signedWrapOut(signedWrapOut), .sumDone(sumDone));
	bya_mem_model mem_u (.fetchAddr(fetchAddr), .fetchData(fetchData),
		.derefAddr(derefAddr), .derefData(derefData));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic printVerdict();
		$display("checks %0d mismatches %0d", checksDone, badCount);
		if (badCount == 0 && checksDone > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : printVerdict
	task automatic loadAcc(input logic [7:0] a, input logic c);
		@(posedge clk);
		accLoad <= 1'b1;
		accLoadData <= a;
		carryLoad <= 1'b1;
		carryLoadValue <= c;
		@(posedge clk);
		accLoad <= 1'b0;
		carryLoad <= 1'b0;
		accExp = a;
		cExp = c;
	endtask : loadAcc
	task automatic runOp(input logic [7:0] op, input logic [7:0] val, input logic [1:0] bank);
		logic [8:0] s;
		logic [4:0] n;
		logic [7:0] w, arg;
		logic cin;
		arg = val;
		if (op[3]) mem_u.mem[{1'b0, bank, op[2:0]}] = val;
		else if (op[2:1] == 2'b11) begin
			mem_u.mem[{3'h0, bank, 2'h0, op[0]}] = 8'h50;
			mem_u.mem[8'h50] = val;
		end else if (op[0]) begin
			arg = 8'h40;
			mem_u.mem[8'h40] = val;
		end
		// plain forms ignore the carry flag
		cin = op[4] & cExp;
		s = {1'b0, accExp} + {1'b0, val} + {8'h00, cin};
		n = {1'b0, accExp[3:0]} + {1'b0, val[3:0]} + {4'h0, cin};
		w = {1'b0, accExp[6:0]} + {1'b0, val[6:0]} + {7'h00, cin};
		@(posedge clk);
		instrValid <= 1'b1;
		opcode <= op;
		instrArg <= arg;
		bankSel <= bank;
		@(posedge clk);
		instrValid <= 1'b0;
		#1;
		`CHK(sumDone, 1'b1, "no done")
		`CHK(accOut, s[7:0], "sum")
		`CHK(carryOut, s[8], "carry")
		`CHK(nibbleCarryOut, n[4], "nibble carry")
		`CHK(signedWrapOut, s[8] ^ w[7], "wrap")
		accExp = s[7:0];
		cExp = s[8];
	endtask : runOp
	task automatic refusedAndSumWins();
		@(posedge clk);
		instrValid <= 1'b1;
		opcode <= 8'h04;
		@(posedge clk);
		instrValid <= 1'b0;
		#1;
		`CHK(sumDone, 1'b0, "foreign op done")
		`CHK(accOut, accExp, "foreign op changed acc")
		@(posedge clk);
		instrValid <= 1'b1;
		opcode <= 8'h24;
		instrArg <= 8'h01;
		accLoad <= 1'b1;
		accLoadData <= 8'h99;
		carryLoad <= 1'b1;
		carryLoadValue <= ~&accExp;
		@(posedge clk);
		instrValid <= 1'b0;
		accLoad <= 1'b0;
		carryLoad <= 1'b0;
		#1;
		`CHK(accOut, accExp + 8'h01, "load beat sum")
		`CHK(carryOut, &accExp, "carry load beat sum")
		accExp = accExp + 8'h01;
	endtask : refusedAndSumWins
	task automatic midReset();
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK({accOut, carryOut, nibbleCarryOut, signedWrapOut, sumDone}, 12'h000, "mid reset")
		{accExp, cExp} = '0;
		runOp(8'h35, 8'hc8, 2'h2);
	endtask : midReset
	task automatic backToBack();
		loadAcc(8'hff, 1'b0);
		@(posedge clk);
		instrValid <= 1'b1;
		opcode <= 8'h24;
		instrArg <= 8'h01;
		@(posedge clk);
		opcode <= 8'h34;
		@(posedge clk);
		instrValid <= 1'b0;
		#1;
		`CHK(accOut, 8'h02, "chained carry")
		`CHK(carryOut, 1'b0, "chained carry flag")
		`CHK(sumDone, 1'b1, "chained done")
	endtask : backToBack
	initial begin
		{rst, instrValid, accLoad, carryLoad, carryLoadValue} = 5'h10;
		{opcode, instrArg, accLoadData, bankSel} = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK({accOut, carryOut, nibbleCarryOut, signedWrapOut, sumDone}, 12'h000, "reset")
		for (int k = 0; k < 12; k++) begin
			loadAcc(accs[k], k[0]);
			runOp(ops[k], vals[k], k[1:0]);
			if (k == 4) `CHK(accOut, 8'h6d, "example sum")
		end
		refusedAndSumWins();
		backToBack();
		midReset();
		printVerdict();
	end
	initial begin
		#(40 * 1000);
		badCount++;
		printVerdict();
	end
endmodule : bya_byte_adder_tb_top
